// ### design/ltb_transfer_ctrl.sv
// Front-panel breaker button logic driving utility and genset switches
// Assumes button pins asynchronous; mode and availability inputs on clk_in
`include "ltb_params.svh"
// How it works
// - Genset transfer presses count only in manual mode with genset available.
// - Normal: genset press opens utility, closes genset; later presses do nothing.
// - Alternative: first genset press as normal, further presses toggle genset drive.
// - Single-switch: manual open press with genset on load opens genset switch.
// - Dual-switch: utility transfer presses ignored outside manual mode.
// - Normal: utility press with utility available opens genset, closes utility.
// - Alternative: further utility presses toggle utility drive, genset stays open.
// - Automatic: start request with genset available opens utility then closes genset.
module ltb_transfer_ctrl (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Operator buttons
    input  wire logic to_genset_button_in,
    input  wire logic to_utility_button_in,
    input  wire logic open_genset_button_in,
    // Mode and conditions
    input  wire logic manual_mode_in,
    input  wire logic auto_mode_in,
    input  wire logic start_request_in,
    input  wire logic genset_avail_in,
    input  wire logic utility_avail_in,
    // Configuration
    input  wire logic alt_behaviour_in,
    input  wire logic dual_switch_in,
    // Switch drives
    output logic      close_genset_out,
    output logic      close_utility_out
);
    logic gs_press;
    logic ut_press;
    logic op_press;
    logic gs_latched;
    logic ut_latched;
    logic gs_valid;
    logic ut_valid;
    logic op_valid;
    ltb_pkg::ltb_auto_e auto_st;
    ltb_pkg::ltb_auto_e next_auto_st;

    ltb_press_detect u_gs (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .button_in (to_genset_button_in),
        .press_out (gs_press)
    );
    ltb_press_detect u_ut (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .button_in (to_utility_button_in),
        .press_out (ut_press)
    );
    ltb_press_detect u_op (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .button_in (open_genset_button_in),
        .press_out (op_press)
    );

    // Press qualification
    assign gs_valid = gs_press & manual_mode_in & genset_avail_in;
    assign ut_valid = ut_press & manual_mode_in & dual_switch_in & utility_avail_in;
    assign op_valid = op_press & manual_mode_in & ~dual_switch_in;

    // Automatic transfer sequence
    always_comb begin
        next_auto_st = auto_st;
        case (auto_st)
            ltb_pkg::LTB_ST_IDLE: begin
                if (auto_mode_in && start_request_in && genset_avail_in && !close_genset_out)
                    next_auto_st = ltb_pkg::LTB_ST_OPEN_UTL;
            end
            ltb_pkg::LTB_ST_OPEN_UTL: next_auto_st = ltb_pkg::LTB_ST_CLOSE_GS;
            ltb_pkg::LTB_ST_CLOSE_GS: next_auto_st = ltb_pkg::LTB_ST_IDLE;
            default:                  next_auto_st = ltb_pkg::LTB_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in)
            auto_st <= ltb_pkg::LTB_ST_IDLE;
        else
            auto_st <= next_auto_st;
    end

    // First-press latches, cleared when the other side takes the load
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            gs_latched <= 1'b0;
            ut_latched <= 1'b0;
        end else if (auto_st == ltb_pkg::LTB_ST_CLOSE_GS) begin
            // Genset takes the load, a stale utility latch would block
            ut_latched <= 1'b0;
        end else if (auto_st == ltb_pkg::LTB_ST_IDLE) begin
            // Same priority as the drives, so a lost press latches nothing
            if (gs_valid) begin
                if (!gs_latched && !close_genset_out) begin
                    gs_latched <= 1'b1;
                    ut_latched <= 1'b0;
                end
            end else if (ut_valid) begin
                if (!ut_latched && !close_utility_out) begin
                    ut_latched <= 1'b1;
                    gs_latched <= 1'b0;
                end
            end else if (op_valid) begin
                gs_latched <= 1'b0;
            end
        end
    end

    // Switch drives
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            close_genset_out  <= `LTB_RST_GEN_DRV;
            close_utility_out <= `LTB_RST_UTIL_DRV;
        end else if (auto_st == ltb_pkg::LTB_ST_OPEN_UTL) begin
            close_utility_out <= 1'b0;
        end else if (auto_st == ltb_pkg::LTB_ST_CLOSE_GS) begin
            close_genset_out  <= 1'b1;
        end else if (gs_valid) begin
            if (!gs_latched && !close_genset_out) begin
                close_utility_out <= 1'b0;
                close_genset_out  <= 1'b1;
            end else if (gs_latched && alt_behaviour_in) begin
                close_utility_out <= 1'b0;
                close_genset_out  <= ~close_genset_out;
            end
        end else if (ut_valid) begin
            if (!ut_latched && !close_utility_out) begin
                close_genset_out  <= 1'b0;
                close_utility_out <= 1'b1;
            end else if (ut_latched && alt_behaviour_in) begin
                close_genset_out  <= 1'b0;
                close_utility_out <= ~close_utility_out;
            end
        end else if (op_valid && close_genset_out) begin
            close_genset_out <= 1'b0;
        end
    end

    a_gs_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gs_press && !(manual_mode_in && genset_avail_in) && !ut_valid && !op_valid
         && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("genset press not ignored");
    a_gs_normal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gs_valid && !gs_latched && !close_genset_out && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> close_genset_out && !close_utility_out)
        else $error("genset transfer failed");
    a_gs_normal_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gs_valid && gs_latched && !alt_behaviour_in && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("repeat press changed drives");
    a_gs_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gs_valid && gs_latched && alt_behaviour_in && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> close_genset_out != $past(close_genset_out) && !close_utility_out)
        else $error("genset toggle failed");
    a_open_genset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (op_valid && !gs_valid && !ut_valid && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> !close_genset_out)
        else $error("open genset failed");
    a_open_again: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (op_valid && !close_genset_out && !gs_valid && !ut_valid && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("repeat open press changed drives");
    a_open_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (op_press && (!manual_mode_in || dual_switch_in) && !gs_valid && !ut_valid && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("open press not ignored");
    a_ut_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ut_press && !manual_mode_in && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_utility_out))
        else $error("utility press not ignored");
    a_ut_single_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ut_press && !dual_switch_in && !gs_valid && !op_valid && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("utility press acted on single switch");
    a_ut_unavail_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ut_press && !utility_avail_in && !gs_valid && !op_valid && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("utility press acted without utility");
    a_ut_normal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ut_valid && !gs_valid && !ut_latched && !close_utility_out && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> close_utility_out && !close_genset_out)
        else $error("utility transfer failed");
    a_ut_normal_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ut_valid && !gs_valid && ut_latched && !alt_behaviour_in && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("repeat utility press changed drives");
    a_ut_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ut_valid && !gs_valid && ut_latched && alt_behaviour_in && auto_st == ltb_pkg::LTB_ST_IDLE)
        |=> close_utility_out != $past(close_utility_out) && !close_genset_out)
        else $error("utility toggle failed");
    a_auto_seq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (auto_st == ltb_pkg::LTB_ST_IDLE && next_auto_st == ltb_pkg::LTB_ST_OPEN_UTL)
        |=> ##1 !close_utility_out ##1 close_genset_out)
        else $error("auto transfer order wrong");
    a_auto_open: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (auto_st == ltb_pkg::LTB_ST_OPEN_UTL)
        |=> !close_utility_out)
        else $error("auto sequence left utility closed");
    a_auto_close: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (auto_st == ltb_pkg::LTB_ST_CLOSE_GS)
        |=> close_genset_out && !close_utility_out)
        else $error("auto sequence did not close genset");
    a_auto_needs_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (auto_st == ltb_pkg::LTB_ST_IDLE && !auto_mode_in)
        |=> auto_st == ltb_pkg::LTB_ST_IDLE)
        else $error("auto sequence started outside automatic mode");
    // Drives change only on a qualified press or the automatic sequence
    a_drives_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (auto_st == ltb_pkg::LTB_ST_IDLE && !gs_press && !ut_press && !op_press)
        |=> $stable(close_genset_out) && $stable(close_utility_out))
        else $error("drives changed without a press");
    // Both switches closed would parallel utility and genset
    a_drive_interlock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !(close_genset_out && close_utility_out))
        else $error("both switch drives closed");

    c_gs_transfer: cover property (@(posedge clk_in) gs_valid && !gs_latched);
    c_open:        cover property (@(posedge clk_in) op_valid && close_genset_out);
    c_gs_toggle:   cover property (@(posedge clk_in) gs_valid && gs_latched && alt_behaviour_in);
    c_ut_transfer: cover property (@(posedge clk_in) ut_valid && !ut_latched);
    c_auto:        cover property (@(posedge clk_in) auto_st == ltb_pkg::LTB_ST_CLOSE_GS);
endmodule : ltb_transfer_ctrl

// ### include/ltb_params.svh
// Constants for the load transfer button control block
// Assumes inclusion by bare name from the design files
`ifndef LTB_PARAMS_SVH
`define LTB_PARAMS_SVH
`define LTB_SYNC_STAGES  2
`define LTB_RST_GEN_DRV  1'b0
`define LTB_RST_UTIL_DRV 1'b1
`endif

// ### include/ltb_pkg.sv
// Types for the load transfer button control block
// Assumes nothing beyond a SystemVerilog compiler
package ltb_pkg;
    typedef enum logic [1:0] {
        LTB_ST_IDLE     = 2'b00,
        LTB_ST_OPEN_UTL = 2'b01,
        LTB_ST_CLOSE_GS = 2'b10
    } ltb_auto_e;
endpackage : ltb_pkg

// ### design/ltb_press_detect.sv
// Button synchroniser and rising edge detector
// Assumes an asynchronous active-high button level
`include "ltb_params.svh"
module ltb_press_detect (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Button
    input  wire logic button_in,
    output logic      press_out
);
    logic sync_a;
    logic sync_b;
    logic prev;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev   <= 1'b0;
        end else begin
            sync_a <= button_in;
            sync_b <= sync_a;
            prev   <= sync_b;
        end
    end

    assign press_out = sync_b & ~prev;

    a_press_single: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        press_out |=> !press_out)
        else $error("press lasted more than one cycle");
endmodule : ltb_press_detect

// ### tb/ltb_button_model.sv
// Operator button model: holds one button for a chosen time, then lets go
// Assumes the clock shared with the block under test
module ltb_button_model (
    // Clock
    input  wire logic clk_in,
    // Button levels
    output logic      to_genset_out,
    output logic      to_utility_out,
    output logic      open_genset_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {to_genset_out, to_utility_out, open_genset_out} = 3'h0;
    end

    // Released long enough for the drives to settle before the next press
    task automatic press(input int sel, input int hold);
        @(posedge clk_in);
        {to_genset_out, to_utility_out, open_genset_out} <= 3'h4 >> sel;
        repeat (hold) @(posedge clk_in);
        {to_genset_out, to_utility_out, open_genset_out} <= 3'h0;
        repeat (8) @(posedge clk_in);
    endtask : press
endmodule : ltb_button_model

// ### tb/tb_top.sv
// Self-checking bench for the load transfer button control block
// Assumes the button model drives the three button pins
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, gb, ub, ob, man, aut, start, g_av, u_av, alt, dual, cg, cu;
    int   fail_count = 0;
    int   cmp_count  = 0;

    ltb_button_model ltb_button_model_inst (.clk_in(clk), .to_genset_out(gb), .to_utility_out(ub),
        .open_genset_out(ob));
    ltb_transfer_ctrl ltb_transfer_ctrl_inst (.clk_in(clk), .rst_n_in(rst_n), .to_genset_button_in(gb),
        .to_utility_button_in(ub), .open_genset_button_in(ob), .manual_mode_in(man), .auto_mode_in(aut),
        .start_request_in(start), .genset_avail_in(g_av), .utility_avail_in(u_av),
        .alt_behaviour_in(alt), .dual_switch_in(dual), .close_genset_out(cg), .close_utility_out(cu));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic eg, input logic eu);
        #1;
        cmp_count++;
        if ({cg, cu} !== {eg, eu}) begin
            fail_count++;
            $display("ERROR %s expected %b%b seen %b%b", name, eg, eu, cg, cu);
        end
    endtask : chk

    // Order: manual, auto, start, genset avail, utility avail, alt, dual
    task automatic cfg(input logic [6:0] v);
        @(posedge clk);
        {man, aut, start, g_av, u_av, alt, dual} <= v;
    endtask : cfg

    task automatic pr(input int sel, input int hold, input string name, input logic eg, input logic eu);
        ltb_button_model_inst.press(sel, hold);
        chk(name, eg, eu);
    endtask : pr

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        {man, aut, start, g_av, u_av, alt, dual} = 7'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset", 1'b0, 1'b1);
        cfg(7'h08);
        pr(0, 2, "gen_nomanual", 1'b0, 1'b1);
        cfg(7'h40);
        pr(0, 2, "gen_noavail", 1'b0, 1'b1);
        cfg(7'h4c);
        pr(0, 2, "gen_first", 1'b1, 1'b0);
        pr(0, 2, "gen_again", 1'b1, 1'b0);
        cfg(7'h4d);
        pr(1, 2, "util_first", 1'b0, 1'b1);
        pr(1, 2, "util_again", 1'b0, 1'b1);
        pr(0, 2, "gen_back", 1'b1, 1'b0);
        cfg(7'h49);
        pr(1, 2, "util_noavail", 1'b1, 1'b0);
        pr(2, 2, "open_dual", 1'b1, 1'b0);
        cfg(7'h0d);
        pr(1, 2, "util_nomanual", 1'b1, 1'b0);
        cfg(7'h4f);
        pr(0, 20, "gen_toggle_hold", 1'b0, 1'b0);
        pr(0, 2, "gen_toggle", 1'b1, 1'b0);
        pr(1, 2, "util_alt_first", 1'b0, 1'b1);
        pr(1, 20, "util_toggle_hold", 1'b0, 1'b0);
        pr(1, 2, "util_toggle", 1'b0, 1'b1);
        cfg(7'h4c);
        pr(0, 2, "gen_single", 1'b1, 1'b0);
        pr(1, 2, "util_single", 1'b1, 1'b0);
        cfg(7'h0c);
        pr(2, 2, "open_nomanual", 1'b1, 1'b0);
        cfg(7'h4c);
        pr(2, 2, "open", 1'b0, 1'b0);
        pr(2, 2, "open_again", 1'b0, 1'b0);
        cfg(7'h4d);
        pr(1, 2, "util_before_auto", 1'b0, 1'b1);
        cfg(7'h35);
        repeat (6) @(posedge clk);
        chk("auto_no_genset", 1'b0, 1'b1);
        cfg(7'h3d);
        repeat (6) @(posedge clk);
        chk("auto_transfer", 1'b1, 1'b0);
        cfg(7'h4d);
        pr(1, 2, "util_after_auto", 1'b0, 1'b1);
        cfg(7'h3d);
        repeat (6) @(posedge clk);
        chk("auto_again", 1'b1, 1'b0);
        cfg(7'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset_again", 1'b0, 1'b1);
        close_out();
    end
endmodule : tb_top
